// *** dms_map.svh ***
// register offsets, field positions, reset values and widths of the mac slice
// assumes a 32-bit avalon-mm slave with byte addresses and a 20 mhz system clock
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH

// ----------------------------------------------------------------------
// datapath widths
// ----------------------------------------------------------------------
`define DMS_A_W 27
`define DMS_B_W 18
`define DMS_PROD_W 45
`define DMS_ACC_W 48
`define DMS_LANE_W 12
`define DMS_LANES 4
`define DMS_XOR_IN_W 96
`define DMS_XOR_OUT_W 8

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DMS_ADDR_W 5
`define DMS_OFS_CTRL 5'h00
`define DMS_OFS_PAT_LO 5'h04
`define DMS_OFS_PAT_HI 5'h08
`define DMS_OFS_MASK_LO 5'h0c
`define DMS_OFS_MASK_HI 5'h10
`define DMS_OFS_STATUS 5'h14
`define DMS_OFS_ACC_LO 5'h18
`define DMS_OFS_ACC_HI 5'h1c

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define DMS_CTRL_W 19
`define DMS_CTRL_BYPASS 0
`define DMS_CTRL_SIMD_LO 1
`define DMS_CTRL_SIMD_HI 2
`define DMS_CTRL_SUB 3
`define DMS_CTRL_ACC 4
`define DMS_CTRL_CNT 5
`define DMS_CTRL_CNT_DOWN 6
`define DMS_CTRL_PRE_SUB 7
`define DMS_CTRL_LOGIC 8
`define DMS_CTRL_FUNC_LO 9
`define DMS_CTRL_FUNC_HI 12
`define DMS_CTRL_XW_LO 13
`define DMS_CTRL_XW_HI 14
`define DMS_CTRL_ADREG 15
`define DMS_CTRL_MREG 16
`define DMS_CTRL_AREG 17
`define DMS_CTRL_PRE_EN 18

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DMS_CTRL_RST 19'h0_0000
`define DMS_PAT_RST 48'h0000_0000_0000
`define DMS_MASK_RST 48'h0000_0000_0000
`define DMS_ACC_RST 48'h0000_0000_0000
`define DMS_RDATA_RST 32'h0000_0000

`endif

// *** dms_pkg.sv ***
// types shared by the mac slice modules
// assumes dms_map.svh for widths and field positions
package dms_pkg;

  // simd split of the 48-bit adder
  typedef enum logic [1:0] {
    DMS_SIMD_ONE48 = 2'b00,
    DMS_SIMD_TWO24 = 2'b01,
    DMS_SIMD_FOUR12 = 2'b10
  } dms_simd_type;

  // ten bitwise functions of x and y
  typedef enum logic [3:0] {
    DMS_LF_AND = 4'h0,
    DMS_LF_OR = 4'h1,
    DMS_LF_XOR = 4'h2,
    DMS_LF_XNOR = 4'h3,
    DMS_LF_NAND = 4'h4,
    DMS_LF_NOR = 4'h5,
    DMS_LF_X_ANDN_Y = 4'h6,
    DMS_LF_X_ORN_Y = 4'h7,
    DMS_LF_NX_AND_Y = 4'h8,
    DMS_LF_NX_OR_Y = 4'h9
  } dms_lfunc_type;

  // segment width of the wide xor
  typedef enum logic [1:0] {
    DMS_XW_12 = 2'b00,
    DMS_XW_24 = 2'b01,
    DMS_XW_48 = 2'b10,
    DMS_XW_96 = 2'b11
  } dms_xw_type;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    DMS_BUS_IDLE = 2'b01,
    DMS_BUS_ANSWER = 2'b10
  } dms_bus_type;

endpackage : dms_pkg

// *** dms_xor_reduce.sv ***
// wide xor reduction over 12-bit segments of a 96-bit word
// purely combinational; the caller registers the result
`timescale 1ns/100ps
`include "dms_map.svh"

module dms_xor_reduce (
  input wire logic [`DMS_XOR_IN_W-1:0] data_i,
  input wire dms_pkg::dms_xw_type width_i,
  output logic [`DMS_XOR_OUT_W-1:0] xor_o
);
  import dms_pkg::*;

  logic [`DMS_XOR_OUT_W-1:0] seg;

  // ----------------------------------------------------------------------
  // per-segment parity
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `DMS_XOR_OUT_W; g++) begin : g_seg
      assign seg[g] = ^data_i[g*`DMS_LANE_W +: `DMS_LANE_W];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // merge segments to the chosen width; results sit in the low bits
  // ----------------------------------------------------------------------
  always_comb begin
    xor_o = '0;
    unique case (width_i)
      DMS_XW_12: xor_o = seg;
      DMS_XW_24: xor_o = {4'h0, seg[7] ^ seg[6], seg[5] ^ seg[4], seg[3] ^ seg[2],
                          seg[1] ^ seg[0]};
      DMS_XW_48: xor_o = {6'h00, ^seg[7:4], ^seg[3:0]};
      DMS_XW_96: xor_o = {7'h00, ^seg};
    endcase
  end

endmodule : dms_xor_reduce

// *** dms_mac_slice.sv ***
// multiply-accumulate slice with pre-adder, simd adder, logic unit,
// wide xor and pattern detector; configured over avalon-mm
// assumes operands come from logic on sys_clk_i, so they are not synchronised
//
// Function
// RULE1: signed 27 by 18 multiply giving the full signed product
// RULE2: 48-bit accumulator summing results over successive cycles
// RULE3: runtime bypass of the multiplier feeding a 48-bit operand directly
// RULE4: simd split into two 24-bit or four 12-bit lanes, no carry between
// RULE5: logic unit with ten selectable bitwise functions of both operands
// RULE6: pre-adder sums or subtracts two operands ahead of the multiplier
// RULE7: 96-bit xor reduction over 12, 24, 48 or 96-bit segments
// RULE8: 48-bit masked pattern detector on the result, for rounding
// RULE9: pattern detector with logic unit evaluates 96-bit-wide logic functions
// RULE10: accumulator counts up or down by one on each enabled edge
// RULE11: optional pipeline registers per stage, each adding exactly one cycle
`timescale 1ns/100ps
`include "dms_map.svh"

module dms_mac_slice (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [`DMS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // operands and results
  input wire logic ce_i,
  input wire logic [`DMS_A_W-1:0] a_i,
  input wire logic [`DMS_A_W-1:0] d_i,
  input wire logic [`DMS_B_W-1:0] b_i,
  input wire logic [`DMS_ACC_W-1:0] x_i,
  input wire logic [`DMS_ACC_W-1:0] c_i,
  output logic [`DMS_ACC_W-1:0] p_o,
  output logic pat_match_o,
  output logic pat_bmatch_o,
  output logic [`DMS_XOR_OUT_W-1:0] xor_o
);
  import dms_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  dms_bus_type bus_q;
  logic [`DMS_CTRL_W-1:0] ctrl_q;
  logic [`DMS_ACC_W-1:0] pat_q, mask_q, p_q;
  logic [31:0] rdata_q;
  logic match_q, bmatch_q;
  logic [`DMS_XOR_OUT_W-1:0] xor_q, xor_c;
  logic req, wr_go;
  logic [`DMS_A_W-1:0] ad_c, s1_ad_q, s1_ad;
  logic [`DMS_B_W-1:0] s1_b_q, s1_b;
  logic [`DMS_ACC_W-1:0] s1_x_q, s1_x, s1_c_q, s1_c;
  logic signed [`DMS_PROD_W-1:0] prod_c, s2_prod_q, s2_prod;
  logic [`DMS_ACC_W-1:0] s2_x_q, s2_x, s2_c_q, s2_c;
  logic [`DMS_ACC_W-1:0] x_c, s3_x_q, s3_x, s3_c_q, s3_c;
  logic [`DMS_ACC_W-1:0] y_c, xin_c, sum_c, logic_c, p_d;
  logic [`DMS_LANES-1:0] cin, cout, brk;
  dms_simd_type simd;
  dms_lfunc_type lfunc;
  dms_xw_type xw;

  assign simd = dms_simd_type'(ctrl_q[`DMS_CTRL_SIMD_HI:`DMS_CTRL_SIMD_LO]);
  assign lfunc = dms_lfunc_type'(ctrl_q[`DMS_CTRL_FUNC_HI:`DMS_CTRL_FUNC_LO]);
  assign xw = dms_xw_type'(ctrl_q[`DMS_CTRL_XW_HI:`DMS_CTRL_XW_LO]);

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer edge
  // ----------------------------------------------------------------------
  assign req = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i && (bus_q == DMS_BUS_ANSWER);

  // waitrequest is the idle bit, so it stays high between requests
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bus_q <= DMS_BUS_IDLE;
    end else begin
      unique case (bus_q)
        DMS_BUS_IDLE: if (req) bus_q <= DMS_BUS_ANSWER;
        DMS_BUS_ANSWER: bus_q <= DMS_BUS_IDLE;
      endcase
    end
  end
  assign avs_waitrequest_o = bus_q[0];

  // read data captured in the wait cycle, stands through the answer edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= `DMS_RDATA_RST;
    end else if (avs_read_i && bus_q == DMS_BUS_IDLE) begin
      unique case (avs_address_i)
        `DMS_OFS_CTRL: rdata_q <= {13'h0000, ctrl_q};
        `DMS_OFS_PAT_LO: rdata_q <= pat_q[31:0];
        `DMS_OFS_PAT_HI: rdata_q <= {16'h0000, pat_q[47:32]};
        `DMS_OFS_MASK_LO: rdata_q <= mask_q[31:0];
        `DMS_OFS_MASK_HI: rdata_q <= {16'h0000, mask_q[47:32]};
        `DMS_OFS_STATUS: rdata_q <= {22'h00_0000, xor_q, bmatch_q, match_q};
        `DMS_OFS_ACC_LO: rdata_q <= p_q[31:0];
        `DMS_OFS_ACC_HI: rdata_q <= {16'h0000, p_q[47:32]};
        default: rdata_q <= `DMS_RDATA_RST;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

  // configuration writes take effect at the answer edge only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `DMS_CTRL_RST;
      pat_q <= `DMS_PAT_RST;
      mask_q <= `DMS_MASK_RST;
    end else if (wr_go) begin
      unique case (avs_address_i)
        `DMS_OFS_CTRL: ctrl_q <= `DMS_CTRL_W'(merge({13'h0000, ctrl_q}, avs_writedata_i,
                                                    avs_byteenable_i));
        `DMS_OFS_PAT_LO: pat_q[31:0] <= merge(pat_q[31:0], avs_writedata_i, avs_byteenable_i);
        `DMS_OFS_PAT_HI: pat_q[47:32] <= 16'(merge({16'h0000, pat_q[47:32]}, avs_writedata_i,
                                                  avs_byteenable_i));
        `DMS_OFS_MASK_LO: mask_q[31:0] <= merge(mask_q[31:0], avs_writedata_i,
                                                avs_byteenable_i);
        `DMS_OFS_MASK_HI: mask_q[47:32] <= 16'(merge({16'h0000, mask_q[47:32]},
                                                    avs_writedata_i, avs_byteenable_i));
        default: ; // read-only or unmapped: write ignored
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // stage 1: pre-adder, wraps at 27 bits like the operands
  // ----------------------------------------------------------------------
  always_comb begin
    ad_c = a_i;
    if (ctrl_q[`DMS_CTRL_PRE_EN]) begin
      ad_c = ctrl_q[`DMS_CTRL_PRE_SUB] ? a_i - d_i : a_i + d_i; // RULE6
    end
  end

  // operands ride along so every path sees the same latency
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_ad_q <= '0;
      s1_b_q <= '0;
      s1_x_q <= '0;
      s1_c_q <= '0;
    end else if (ce_i) begin
      s1_ad_q <= ad_c;
      s1_b_q <= b_i;
      s1_x_q <= x_i;
      s1_c_q <= c_i;
    end
  end
  assign s1_ad = ctrl_q[`DMS_CTRL_ADREG] ? s1_ad_q : ad_c; // RULE11
  assign s1_b = ctrl_q[`DMS_CTRL_ADREG] ? s1_b_q : b_i;
  assign s1_x = ctrl_q[`DMS_CTRL_ADREG] ? s1_x_q : x_i;
  assign s1_c = ctrl_q[`DMS_CTRL_ADREG] ? s1_c_q : c_i;

  // ----------------------------------------------------------------------
  // stage 2: signed multiply
  // ----------------------------------------------------------------------
  assign prod_c = $signed(s1_ad) * $signed(s1_b); // RULE1

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s2_prod_q <= '0;
      s2_x_q <= '0;
      s2_c_q <= '0;
    end else if (ce_i) begin
      s2_prod_q <= prod_c;
      s2_x_q <= s1_x;
      s2_c_q <= s1_c;
    end
  end
  assign s2_prod = ctrl_q[`DMS_CTRL_MREG] ? s2_prod_q : prod_c; // RULE11
  assign s2_x = ctrl_q[`DMS_CTRL_MREG] ? s2_x_q : s1_x;
  assign s2_c = ctrl_q[`DMS_CTRL_MREG] ? s2_c_q : s1_c;

  // ----------------------------------------------------------------------
  // stage 3: accumulator input select and register
  // ----------------------------------------------------------------------
  // bypass hands the wide operand straight to the adder and logic unit
  assign x_c = ctrl_q[`DMS_CTRL_BYPASS] ? s2_x :
               {{(`DMS_ACC_W - `DMS_PROD_W){s2_prod[`DMS_PROD_W-1]}}, s2_prod}; // RULE3

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s3_x_q <= '0;
      s3_c_q <= '0;
    end else if (ce_i) begin
      s3_x_q <= x_c;
      s3_c_q <= s2_c;
    end
  end
  assign s3_x = ctrl_q[`DMS_CTRL_AREG] ? s3_x_q : x_c; // RULE11
  assign s3_c = ctrl_q[`DMS_CTRL_AREG] ? s3_c_q : s2_c;

  // ----------------------------------------------------------------------
  // simd adder: y +/- x, carry chain cut at lane borders
  // ----------------------------------------------------------------------
  assign y_c = ctrl_q[`DMS_CTRL_ACC] ? p_q : s3_c; // RULE2
  assign xin_c = ctrl_q[`DMS_CTRL_SUB] ? ~s3_x : s3_x;
  assign brk[0] = 1'b1;
  assign brk[1] = (simd == DMS_SIMD_FOUR12);
  assign brk[2] = (simd == DMS_SIMD_FOUR12) || (simd == DMS_SIMD_TWO24);
  assign brk[3] = (simd == DMS_SIMD_FOUR12);

  genvar g;
  generate
    for (g = 0; g < `DMS_LANES; g++) begin : g_lane
      if (g == 0) begin : g_first
        assign cin[g] = ctrl_q[`DMS_CTRL_SUB];
      end else begin : g_rest
        // a border reloads the subtract carry instead of the neighbour's
        assign cin[g] = brk[g] ? ctrl_q[`DMS_CTRL_SUB] : cout[g-1]; // RULE4
      end
      assign {cout[g], sum_c[g*`DMS_LANE_W +: `DMS_LANE_W]} =
        {1'b0, y_c[g*`DMS_LANE_W +: `DMS_LANE_W]} +
        {1'b0, xin_c[g*`DMS_LANE_W +: `DMS_LANE_W]} +
        {{`DMS_LANE_W{1'b0}}, cin[g]};
    end
  endgenerate

  // ----------------------------------------------------------------------
  // logic unit
  // ----------------------------------------------------------------------
  always_comb begin
    logic_c = '0;
    unique case (lfunc) // RULE5
      DMS_LF_AND: logic_c = s3_x & y_c;
      DMS_LF_OR: logic_c = s3_x | y_c;
      DMS_LF_XOR: logic_c = s3_x ^ y_c;
      DMS_LF_XNOR: logic_c = ~(s3_x ^ y_c);
      DMS_LF_NAND: logic_c = ~(s3_x & y_c);
      DMS_LF_NOR: logic_c = ~(s3_x | y_c);
      DMS_LF_X_ANDN_Y: logic_c = s3_x & ~y_c;
      DMS_LF_X_ORN_Y: logic_c = s3_x | ~y_c;
      DMS_LF_NX_AND_Y: logic_c = ~s3_x & y_c;
      DMS_LF_NX_OR_Y: logic_c = ~s3_x | y_c;
      default: logic_c = '0; // codes 10 to 15 give zero
    endcase
  end

  // ----------------------------------------------------------------------
  // accumulator next value; counter mode wins over the alu
  // ----------------------------------------------------------------------
  always_comb begin
    if (ctrl_q[`DMS_CTRL_CNT]) begin
      p_d = ctrl_q[`DMS_CTRL_CNT_DOWN] ? p_q - 48'h0000_0000_0001
                                       : p_q + 48'h0000_0000_0001; // RULE10
    end else if (ctrl_q[`DMS_CTRL_LOGIC]) begin
      p_d = logic_c;
    end else begin
      p_d = sum_c;
    end
  end

  // result register, always present; it is the accumulator itself
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      p_q <= `DMS_ACC_RST;
    end else if (ce_i) begin
      p_q <= p_d; // RULE2
    end
  end
  assign p_o = p_q;

  // ----------------------------------------------------------------------
  // pattern detector, judged on the value entering the accumulator
  // ----------------------------------------------------------------------
  // flags line up with p_o; a logic-unit result makes it a 96-input test
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      match_q <= 1'b0;
      bmatch_q <= 1'b0;
    end else if (ce_i) begin
      match_q <= ((p_d ^ pat_q) & ~mask_q) == '0; // RULE8 RULE9
      bmatch_q <= ((p_d ^ ~pat_q) & ~mask_q) == '0; // RULE8
    end
  end
  assign pat_match_o = match_q;
  assign pat_bmatch_o = bmatch_q;

  // ----------------------------------------------------------------------
  // wide xor over both alu operands, registered with p
  // ----------------------------------------------------------------------
  dms_xor_reduce u_xor (
    .data_i({y_c, s3_x}),
    .width_i(xw),
    .xor_o(xor_c)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      xor_q <= '0;
    end else if (ce_i) begin
      xor_q <= xor_c; // RULE7
    end
  end
  assign xor_o = xor_q;

endmodule : dms_mac_slice

// *** dms_mac_slice_checker.sv ***
// assertion checker for dms_mac_slice, bound to every instance
// assumes full-word register writes and a steady control word while ce_i runs
`timescale 1ns/100ps
`include "dms_map.svh"

module dms_mac_slice_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`DMS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic ce_i,
  input wire logic [`DMS_A_W-1:0] a_i,
  input wire logic [`DMS_A_W-1:0] d_i,
  input wire logic [`DMS_B_W-1:0] b_i,
  input wire logic [`DMS_ACC_W-1:0] x_i,
  input wire logic [`DMS_ACC_W-1:0] c_i,
  input wire logic [`DMS_ACC_W-1:0] p_o,
  input wire logic pat_match_o,
  input wire logic pat_bmatch_o,
  input wire logic [`DMS_XOR_OUT_W-1:0] xor_o
);
  import dms_pkg::*;
  logic [18:0] ctrl_q;
  logic [47:0] pat_q, msk_q, mul_v, lane_v;
  // ----------
  // register shadows
  // ----------
  // taken at the edge that completes a write, as the slave does
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= '0;
      pat_q <= '0;
      msk_q <= '0;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      case (avs_address_i)
        `DMS_OFS_CTRL: ctrl_q <= avs_writedata_i[18:0];
        `DMS_OFS_PAT_LO: pat_q[31:0] <= avs_writedata_i;
        `DMS_OFS_PAT_HI: pat_q[47:32] <= avs_writedata_i[15:0];
        `DMS_OFS_MASK_LO: msk_q[31:0] <= avs_writedata_i;
        `DMS_OFS_MASK_HI: msk_q[47:32] <= avs_writedata_i[15:0];
        default: ;
      endcase
    end
  end
  // all signed, so the product sign-extends; lanes add with no carry between
  assign mul_v = $signed(a_i) * $signed(b_i) + $signed(c_i);
  assign lane_v = {x_i[47:36] + c_i[47:36], x_i[35:24] + c_i[35:24],
                   x_i[23:12] + c_i[23:12], x_i[11:0] + c_i[11:0]};
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------
  // assertions
  // ----------
  chk_mul_plain:
    assert property (ce_i && ctrl_q == '0 |=> p_o == $past(mul_v))
    else $error("plain product wrong");
  chk_mreg_lat:
    assert property ((ce_i && ctrl_q == 19'h1_0000) ##1 (ce_i && $stable(c_i))
      |=> p_o == $past(mul_v, 2))
    else $error("multiplier register latency wrong");
  chk_lane_add:
    assert property (ce_i && ctrl_q == 19'h0_0005 |=> p_o == $past(lane_v))
    else $error("four lane sum wrong");
  chk_logic_xor:
    assert property (ce_i && (ctrl_q & 19'h7_9fff) == 19'h0_0501
      |=> p_o == $past(x_i ^ c_i))
    else $error("logic xor wrong");
  chk_acc_sum:
    assert property (ce_i && ctrl_q == 19'h0_0011 |=> p_o == $past(p_o) + $past(x_i))
    else $error("accumulate wrong");
  chk_count_up:
    assert property (ce_i && ctrl_q == 19'h0_0020 |=> p_o == $past(p_o) + 48'h1)
    else $error("count up wrong");
  chk_count_dn:
    assert property (ce_i && ctrl_q == 19'h0_0060 |=> p_o == $past(p_o) - 48'h1)
    else $error("count down wrong");
  chk_pat_flags:
    assert property (ce_i |=> pat_match_o == (((p_o ^ pat_q) & ~msk_q) == '0)
      && pat_bmatch_o == (((p_o ^ ~pat_q) & ~msk_q) == '0))
    else $error("pattern flags wrong");
  chk_ce_hold:
    assert property (!ce_i |=> $stable(p_o) && $stable(xor_o) && $stable(pat_match_o))
    else $error("outputs moved without enable");
  cov_lanes: cover property (ce_i && ctrl_q == 19'h0_0005);
  cov_match: cover property (pat_match_o && ctrl_q[5]);
  cov_bmatch: cover property (pat_bmatch_o && ctrl_q[8]);
endmodule : dms_mac_slice_checker

bind dms_mac_slice dms_mac_slice_checker u_dms_mac_slice_checker (.*);

// *** dms_fabric_model.sv ***
// operand source standing in for the user logic around the slice
// assumes one clock shared with the slice; stalls at random while running
`timescale 1ns/100ps

module dms_fabric_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic hold_i,
  output logic ce_o,
  output logic [26:0] a_o,
  output logic [26:0] d_o,
  output logic [17:0] b_o,
  output logic [47:0] x_o,
  output logic [47:0] c_o
);
  int seed = 13;
  // ----------
  // operand drive
  // ----------
  // single driver per output: ce_o is unknown until the first edge, while the slice
  // is still in reset; the operands stay unknown until the first enabled edge
  // a stalled source shows inverted values, not held ones, so a slice that
  // samples without enable is caught; hold_i freezes c for pipelined runs
  always @(posedge clk_i) begin : drive
    logic en;
    en = run_i && ($random(seed) % 4 != 0);
    ce_o <= en;
    a_o <= en ? 27'($random(seed)) : ~a_o;
    d_o <= en ? 27'($random(seed)) : ~d_o;
    b_o <= en ? 18'($random(seed)) : ~b_o;
    x_o <= en ? {16'($random(seed)), 32'($random(seed))} : ~x_o;
    c_o <= hold_i ? c_o : (en ? {16'($random(seed)), 32'($random(seed))} : ~c_o);
  end
endmodule : dms_fabric_model

// *** dms_mac_slice_tb_top.sv ***
// self-checking bench: avalon tasks, fabric model, queue-based result model
// assumes the checker is bound and dms_fabric_model drives the operands
`timescale 1ns/100ps
`include "dms_map.svh"

module dms_mac_slice_tb_top;
  import dms_pkg::*;
  logic sys_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, ce_i;
  logic run_q, hold_q, pat_match_o, pat_bmatch_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rv;
  logic [3:0] avs_byteenable_i;
  logic [26:0] a_i, d_i;
  logic [17:0] b_i;
  logic [47:0] x_i, c_i, p_o, mp, pat, msk, er;
  logic [7:0] xor_o, ex;
  logic [18:0] mode;
  logic [55:0] q[$];
  int lat, miscompares, check_count;

  dms_mac_slice u_dms_mac_slice (.*);
  dms_fabric_model u_dms_fabric_model (.clk_i(sys_clk_i), .run_i(run_q), .hold_i(hold_q),
    .ce_o(ce_i), .a_o(a_i), .d_o(d_i), .b_o(b_i), .x_o(x_i), .c_o(c_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ----------
  // tasks
  // ----------
  task automatic cmp_p(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_p
  task automatic cmp_s(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected status at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_s
  task automatic end_sim;
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // one avalon access, held until waitrequest is seen low; read data lands in rv
  task automatic bus(input logic [4:0] ad, input logic w, input logic [31:0] dv);
    int n;
    n = 0;
    avs_address_i <= ad;
    avs_writedata_i <= dv;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    rv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus
  task automatic reset_dut;
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    mp = '0;
    pat = '0;
    msk = '0;
    @(negedge sys_clk_i);
    cmp_p(p_o, '0);
    cmp_s({pat_match_o, pat_bmatch_o, xor_o}, 10'h000);
    @(posedge sys_clk_i);
  endtask : reset_dut
  // control word is only changed while the source is idle
  task automatic run(input logic [18:0] m, input int l, input int cyc, input logic h);
    bus(`DMS_OFS_CTRL, 1'b1, {13'h0000, m});
    mode = m;
    lat = l;
    q.delete();
    run_q <= 1'b1;
    hold_q <= h;
    repeat (cyc) @(posedge sys_clk_i);
    run_q <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask : run
  // behavioural slice: result er and xor ex for the operands at this edge
  task automatic mdl;
    logic [26:0] pa;
    logic [47:0] xx, y, lm;
    logic [95:0] xy;
    int w, g;
    pa = mode[18] ? (mode[7] ? a_i - d_i : a_i + d_i) : a_i;
    if (mode[0]) xx = x_i;
    else xx = $signed(pa) * $signed(b_i);
    y = mode[4] ? mp : c_i;
    w = mode[2:1] == 2'b01 ? 24 : (mode[2:1] == 2'b10 ? 12 : 48);
    lm = (48'h1 << w) - 48'h1;
    er = '0;
    for (int i = 0; i < 48; i += w)
      er |= ((((y >> i) & lm) + (mode[3] ? -((xx >> i) & lm) : (xx >> i) & lm)) & lm) << i;
    if (mode[8]) case (mode[12:9])
      4'h0: er = xx & y;
      4'h1: er = xx | y;
      4'h2: er = xx ^ y;
      4'h3: er = ~(xx ^ y);
      4'h4: er = ~(xx & y);
      4'h5: er = ~(xx | y);
      4'h6: er = xx & ~y;
      4'h7: er = xx | ~y;
      4'h8: er = ~xx & y;
      4'h9: er = ~xx | y;
      default: er = '0;
    endcase
    if (mode[5]) er = mode[6] ? mp - 48'h1 : mp + 48'h1;
    xy = {y, xx};
    g = 1 << mode[14:13];
    ex = '0;
    for (int k = 0; k < 8; k++) ex[k / g] ^= ^xy[12 * k +: 12];
  endtask : mdl
  // ----------
  // result monitor and main sequence
  // ----------
  // one entry per enabled edge, compared lat-1 enabled edges later
  always @(posedge sys_clk_i) begin
    if (rst_n_i === 1'b1 && ce_i === 1'b1) begin
      mdl();
      q.push_back({ex, er});
      if (q.size() >= lat) begin
        {ex, er} = q.pop_front();
        mp = er;
        @(negedge sys_clk_i);
        cmp_p(p_o, er);
        cmp_s({pat_match_o, pat_bmatch_o, xor_o}, {((er ^ pat) & ~msk) == '0,
          ((er ^ ~pat) & ~msk) == '0, ex});
      end
    end
  end
  initial begin
    rst_n_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hf;
    run_q = 1'b0;
    hold_q = 1'b0;
    mode = '0;
    lat = 1;
    miscompares = 0;
    check_count = 0;
    @(posedge sys_clk_i);
    reset_dut();
    bus(`DMS_OFS_CTRL, 1'b0, '0);
    cmp_p(48'(rv), '0);
    run(19'h0_0000, 1, 40, 1'b0);
    run(19'h4_0000, 1, 30, 1'b0);
    run(19'h4_0080, 1, 30, 1'b0);
    run(19'h1_0000, 2, 40, 1'b1);
    run(19'h7_8000, 4, 40, 1'b1);
    for (int i = 0; i < 6; i++) run(19'(1 + 2 * (i % 3) + 8 * (i / 3)), 1, 30, 1'b0);
    bus(`DMS_OFS_MASK_LO, 1'b1, 32'hffff_fff0);
    bus(`DMS_OFS_MASK_HI, 1'b1, 32'h0000_ffff);
    msk = 48'hffff_ffff_fff0;
    for (int f = 0; f < 12; f++) run(19'(257 + (f << 9) + ((f % 4) << 13)), 1, 20, 1'b0);
    reset_dut();
    run(19'h0_0011, 1, 30, 1'b0);
    bus(`DMS_OFS_ACC_LO, 1'b1, 32'h5a5a_5a5a);
    bus(`DMS_OFS_ACC_LO, 1'b0, '0);
    cmp_p(48'(rv), 48'(mp[31:0]));
    bus(`DMS_OFS_ACC_HI, 1'b0, '0);
    cmp_p(48'(rv), 48'(mp[47:32]));
    bus(`DMS_OFS_CTRL, 1'b0, '0);
    cmp_p(48'(rv), 48'h0000_0000_0011);
    reset_dut();
    run(19'h0_0020, 1, 12, 1'b0);
    run(19'h0_0060, 1, 40, 1'b0);
    bus(`DMS_OFS_MASK_LO, 1'b1, 32'h0000_000f);
    msk = 48'h0000_0000_000f;
    // pattern of all ones above the mask: counting up through -16..15 hits both flags
    bus(`DMS_OFS_PAT_LO, 1'b1, 32'hffff_fff0);
    bus(`DMS_OFS_PAT_HI, 1'b1, 32'h0000_ffff);
    pat = 48'hffff_ffff_fff0;
    run(19'h0_0020, 1, 40, 1'b0);
    bus(`DMS_OFS_PAT_HI, 1'b0, '0);
    cmp_p(48'(rv), 48'h0000_0000_ffff);
    bus(`DMS_OFS_STATUS, 1'b0, '0);
    cmp_p(48'(rv), 48'({ex, ((er ^ ~pat) & ~msk) == '0, ((er ^ pat) & ~msk) == '0}));
    end_sim();
  end
endmodule : dms_mac_slice_tb_top
